// >>> src/interval_timer.sv
// One 8-bit interval timer counting in tick steps
module interval_timer
  import ioc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] value,
  input  wire logic              tick,
  input  wire logic              inhibit,
  // Event
  output logic                   expire
);
  typedef struct packed {
    logic [DATA_W-1:0] count;
    logic              run;
    logic              expire;
  } tmr_state_t;

  tmr_state_t state;
  tmr_state_t next_state;

  // Load restarts, tick decrements, zero raises one expire pulse
  always_comb begin
    next_state        = state;
    next_state.expire = 1'b0;
    if (load) begin
      next_state.count = value;
      next_state.run   = (value != '0);
      next_state.expire = (value == '0);
    end else if (inhibit) begin
      next_state.run = 1'b0;
    end else if (state.run && tick) begin
      next_state.count = state.count - 1'b1;
      if (state.count == 8'h01) begin
        next_state.run    = 1'b0;
        next_state.expire = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign expire = state.expire;
endmodule : interval_timer

// >>> src/io_controller_load_functions.sv
// Write-side command functions: rate, buffer, port, mask and timers
// Overview of operation
// - Rate bit 7 high one stop, else two
// - Buffer load write copies data bus byte
// - Port write latches; outputs drive inverted data
// - Mask bit n enables interrupt source n
// - Timer load takes byte; 64 us units
// - Timer reaching zero sets its interrupt bit
// - Loading zero raises timer interrupt immediately
// - Highest selected baud wins; none disables link
// - Discrete reset stops timers, keeps mask, rate, port and buffer
// - Source 7 from timer 5 or input 7
// - Interrupt pending when set bit is unmasked
module io_controller_load_functions
  import ioc_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Host write port
  input  ioc_pkg::host_wr_t      host,
  // Interrupt acknowledge: clears every bit that is set in the vector unless that bit is set again in the same cycle
  input  wire logic [DATA_W-1:0] irq_ack,
  // External input 7 for the shared interrupt source
  input  wire logic              ext_in7,
  // Parallel output port, active low copy of the latched byte
  output logic [DATA_W-1:0]      port_out_n,
  // Transmitter buffer towards the shifter
  output logic [DATA_W-1:0]      xmit_data,
  output logic                   xmit_load,
  // Serial configuration
  output ioc_pkg::line_cfg_t     line_cfg,
  // Interrupt state
  output logic [DATA_W-1:0]      irq_reg,
  output logic                   int_req
);
  import ioc_pkg::*;

  typedef struct packed {
    logic [TICK_W-1:0] prescale;
    logic              tick;
    logic              inhibit;
    logic              sel7_ext;
    logic              ext7_q;
    logic [DATA_W-1:0] rate;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] port_n;
    logic [DATA_W-1:0] xbuf;
    logic              xload;
    logic [DATA_W-1:0] irq;
    logic              intr;
    line_cfg_t         cfg;
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;
  logic [NUM_TIMERS-1:0] tmr_load;
  logic [NUM_TIMERS-1:0] tmr_exp;

  // Highest selected rate wins; zero code means link inhibited
  function automatic logic [2:0] baud_code(input logic [RATE_SEL_W-1:0] s);
    baud_code = BAUD_OFF;
    for (int i = 0; i < RATE_SEL_W; i++) begin
      if (s[i]) begin
        baud_code = 3'(i + 1);
      end
    end
  endfunction : baud_code

  // One write strobe per function; a code outside the map hits nothing
  function automatic logic fn_hit(input host_wr_t   h,
                                  input logic [3:0] code);
    fn_hit = h.wr && (h.fn == code);
  endfunction : fn_hit

  // Decoded write strobes, shared by the register and timer logic
  typedef struct packed {
    logic                  disc;
    logic                  reset_cmd;
    logic                  rate;
    logic                  xmit;
    logic                  port;
    logic                  mask;
    logic [NUM_TIMERS-1:0] tmr;
    logic                  any_tmr;
  } wr_dec_t;

  wr_dec_t dec;

  // Function decode; reset is only bit 0 of a discrete command
  always_comb begin
    dec           = '0;
    dec.disc      = fn_hit(host, FN_DISCRETE);
    dec.reset_cmd = dec.disc && host.data[CMD_RESET_BIT];
    dec.rate      = fn_hit(host, FN_RATE);
    dec.xmit      = fn_hit(host, FN_XMIT);
    dec.port      = fn_hit(host, FN_PORT);
    dec.mask      = fn_hit(host, FN_MASK);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      dec.tmr[i] = fn_hit(host, 4'(FN_TIMER1 + 4'(i)));
    end
    dec.any_tmr   = |dec.tmr;
  end

  // Each timer sees only its own load strobe
  assign tmr_load = dec.tmr;

  // Timer expiries and the input-7 edge onto interrupt bits;
  // bits 2 and 4 belong to receive-side sources outside this block
  function automatic logic [DATA_W-1:0] src_bits(
    input logic [NUM_TIMERS-1:0] expired,
    input logic                  rise7,
    input logic                  sel7
  );
    src_bits             = '0;
    src_bits[IRQ_TIMER1] = expired[0];
    src_bits[IRQ_TIMER2] = expired[1];
    src_bits[IRQ_TIMER3] = expired[2];
    src_bits[IRQ_TIMER4] = expired[3];
    src_bits[IRQ_SRC7]   = sel7 ? rise7 : expired[4];
  endfunction : src_bits

  // The five interval timers
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
    interval_timer u_tmr (
      .clk     (clk),
      .rst_n   (rst_n),
      .load    (tmr_load[g]),
      .value   (host.data),
      .tick    (state.tick),
      .inhibit (state.inhibit),
      .expire  (tmr_exp[g])
    );
  end

  // Write decode, tick prescaler and interrupt register
  always_comb begin
    logic [DATA_W-1:0] set_bits;
    set_bits   = '0;
    next_state = state;
    next_state.xload   = 1'b0;
    next_state.ext7_q  = ext_in7;
    // Prescaler gives one tick per 64 us step; it runs free, so the
    // first step after a load comes anywhere from one cycle to a full
    // step later, and a loaded count n lasts between n-1 and n steps
    if (state.prescale == TICK_W'(TICK_COUNT - 1)) begin
      next_state.prescale = '0;
      next_state.tick     = 1'b1;
    end else begin
      next_state.prescale = state.prescale + 1'b1;
      next_state.tick     = 1'b0;
    end
    // Discrete command: a low bit 0 does nothing to the timers;
    // reset leaves mask, rate, port and buffer untouched
    if (dec.disc) begin
      if (dec.reset_cmd) begin
        next_state.inhibit = 1'b1;
      end
      next_state.sel7_ext = host.data[CMD_SEL7_BIT];
      // Reset forces brk low, the same level that a set break bit gives
      next_state.cfg.brk  = ~host.data[CMD_BREAK_BIT]
                            & ~host.data[CMD_RESET_BIT];
    end
    // Rate byte feeds both stop-bit and baud decode below
    if (dec.rate) begin
      next_state.rate = host.data;
    end
    // Buffer load also pulses the load strobe for one cycle
    if (dec.xmit) begin
      next_state.xbuf  = host.data;
      next_state.xload = 1'b1;
    end
    // Port byte is held inverted, as the pins show it
    if (dec.port) begin
      next_state.port_n = ~host.data;
    end
    // Mask bit n gates interrupt source n
    if (dec.mask) begin
      next_state.mask = host.data;
    end
    // Any timer load lifts the inhibit left by a discrete reset;
    // timers already stopped stay stopped until their own reload
    if (dec.any_tmr) begin
      next_state.inhibit = 1'b0;
    end
    next_state.cfg.one_stop = next_state.rate[RATE_STOP_BIT];
    next_state.cfg.baud_sel =
      baud_code(next_state.rate[RATE_SEL_W-1:0]);
    // Timer events and the input-7 rising edge into the register
    set_bits = src_bits(tmr_exp, ext_in7 & ~state.ext7_q,
                        state.sel7_ext);
    // Set wins over acknowledge in the same cycle
    next_state.irq = (state.irq & ~irq_ack) | set_bits;
    if (dec.reset_cmd) begin
      // Reset clears held bits, keeps same-cycle source events, and sets the transmitter-buffer bit
      next_state.irq = set_bits;
      next_state.irq[IRQ_XMIT] = 1'b1;
    end
    next_state.intr = |(next_state.irq & next_state.mask);
  end

  // State register; power-on holds timers inhibited until loaded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= '0;
      state.inhibit <= 1'b1;
      state.port_n  <= '1;
      // Input 7 starts high so a pin idling high gives no false edge
      state.ext7_q  <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register
  assign port_out_n = state.port_n;
  assign xmit_data  = state.xbuf;
  assign xmit_load  = state.xload;
  assign line_cfg   = state.cfg;
  assign irq_reg    = state.irq;
  assign int_req    = state.intr;
endmodule : io_controller_load_functions

// >>> src/ioc_pkg.sv
// Package: function codes, field positions, carriers and timing counts
package ioc_pkg;
  // Clock rate and timer step
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned TICK_US       = 64;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W        = 11;

  // Number of interval timers and widths
  localparam int unsigned NUM_TIMERS    = 5;
  localparam int unsigned DATA_W        = 8;

  // Write function codes presented on the function select port
  localparam logic [3:0] FN_DISCRETE    = 4'h0;
  localparam logic [3:0] FN_RATE        = 4'h1;
  localparam logic [3:0] FN_XMIT        = 4'h2;
  localparam logic [3:0] FN_PORT        = 4'h3;
  localparam logic [3:0] FN_MASK        = 4'h4;
  localparam logic [3:0] FN_TIMER1      = 4'h5;
  localparam logic [3:0] FN_TIMER5      = 4'h9;

  // Field positions of the rate and discrete command bytes
  localparam int unsigned RATE_STOP_BIT = 7;
  localparam int unsigned RATE_SEL_W    = 7;
  localparam int unsigned CMD_RESET_BIT = 0;
  localparam int unsigned CMD_BREAK_BIT = 1;
  localparam int unsigned CMD_SEL7_BIT  = 2;

  // Interrupt register bit assigned to each timer, and shared source 7
  localparam int unsigned IRQ_TIMER1    = 0;
  localparam int unsigned IRQ_TIMER2    = 1;
  localparam int unsigned IRQ_TIMER3    = 3;
  localparam int unsigned IRQ_TIMER4    = 6;
  localparam int unsigned IRQ_SRC7      = 7;
  localparam int unsigned IRQ_XMIT      = 5;

  // Baud select encoding, 0 means link disabled
  localparam logic [2:0] BAUD_OFF       = 3'h0;

  // Host write strobe with function code and data
  typedef struct packed {
    logic             wr;
    logic [3:0]       fn;
    logic [DATA_W-1:0] data;
  } host_wr_t;

  // Serial configuration handed to the shifting logic
  typedef struct packed {
    logic       one_stop;
    logic [2:0] baud_sel;
    logic       brk;
  } line_cfg_t;
endpackage : ioc_pkg

// >>> verif/host_model.sv
// Host model: one write strobe per bench request
module host_model
  import ioc_pkg::*;
(
  // Clock and request
  input  wire logic              clk,
  input  wire logic              go,
  input  wire logic [3:0]        fn,
  input  wire logic [DATA_W-1:0] dat,
  // Bus towards the device
  output ioc_pkg::host_wr_t      host
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus shows inverted bytes so stale values never look valid
  always_ff @(posedge clk) begin
    host.wr   <= go;
    host.fn   <= go ? fn : ~host.fn;
    host.data <= go ? dat : ~host.data;
  end
endmodule : host_model

// >>> verif/io_controller_load_functions_test.sv
// Bench: scenarios for the write-side load functions
module io_controller_load_functions_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ioc_pkg::*;
  localparam int TK = 4;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, ext_in7 = 1'b0;
  logic [3:0] fn = 4'h0;
  logic [7:0] dat = 8'h00, irq_ack = 8'h00;
  logic [7:0] port_out_n, xmit_data, irq_reg;
  logic       xmit_load, int_req;
  host_wr_t   host;
  line_cfg_t  line_cfg;
  int         err_total = 0, checks = 0, cyc = 0;
  host_model host_u (.clk, .go, .fn, .dat, .host);
  io_controller_load_functions #(.TICK_COUNT(TK)) dut_u (.clk, .rst_n,
    .host, .irq_ack, .ext_in7, .port_out_n, .xmit_data, .xmit_load,
    .line_cfg, .irq_reg, .int_req);
  // Clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Write lands one edge after the model presents it
  task automatic wr(input logic [3:0] f, input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1;
    fn <= f;
    dat <= d;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic ack;
    @(posedge clk);
    irq_ack <= 8'hff;
    @(posedge clk);
    irq_ack <= 8'h00;
  endtask : ack
  task automatic wait_irq(input int b, output int n);
    n = 0;
    while (irq_reg[b] !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_irq
  task automatic t_rate;
    for (int i = 0; i < 7; i++) begin
      wr(FN_RATE, 8'h81 | (8'h01 << i));
      check("baud", line_cfg.baud_sel, 8'(i + 1));
      check("stop", line_cfg.one_stop, 8'h01);
    end
    wr(FN_RATE, 8'h00);
    check("baud", line_cfg.baud_sel, 8'h00);
    check("stop", line_cfg.one_stop, 8'h00);
    $display("test rate done");
  endtask : t_rate
  task automatic t_port_xmit;
    wr(FN_PORT, 8'ha5);
    check("port", port_out_n, 8'h5a);
    wr(FN_XMIT, 8'h3c);
    check("xmit", xmit_data, 8'h3c);
    check("load", xmit_load, 8'h01);
    check("port", port_out_n, 8'h5a);
    $display("test port done");
  endtask : t_port_xmit
  // Zero load, then a reload that must restart the count
  task automatic t_timer;
    int n;
    wr(FN_MASK, 8'h01);
    wr(FN_TIMER1, 8'h00);
    @(posedge clk);
    #1;
    check("irq", irq_reg[IRQ_TIMER1], 8'h01);
    check("int", int_req, 8'h01);
    wr(FN_MASK, 8'h00);
    ack;
    wr(FN_TIMER1, 8'h05);
    wr(FN_TIMER1, 8'h03);
    wait_irq(IRQ_TIMER1, n);
    check("span", 8'(n >= 2 * TK && n <= 3 * TK + 2), 8'h01);
    check("int", int_req, 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_reset;
    wr(FN_RATE, 8'h88);
    ack;
    wr(FN_TIMER1 + 4'h1, 8'h02);
    wr(FN_DISCRETE, 8'h03);
    check("brk", line_cfg.brk, 8'h00);
    repeat (4 * TK) @(posedge clk);
    #1;
    check("irq", irq_reg, 8'h20);
    check("port", port_out_n, 8'h5a);
    check("baud", line_cfg.baud_sel, 8'h04);
    $display("test reset done");
  endtask : t_reset
  task automatic t_src7;
    int n;
    ack;
    wr(FN_DISCRETE, 8'h04);
    check("brk", line_cfg.brk, 8'h01);
    @(posedge clk);
    ext_in7 <= 1'b1;
    wait_irq(IRQ_SRC7, n);
    check("ext7", irq_reg[IRQ_SRC7], 8'h01);
    ack;
    wr(FN_DISCRETE, 8'h02);
    wr(FN_TIMER5, 8'h00);
    wait_irq(IRQ_SRC7, n);
    check("t5", irq_reg[IRQ_SRC7], 8'h01);
    $display("test source7 done");
  endtask : t_src7
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_rate;
    t_port_xmit;
    t_timer;
    t_reset;
    t_src7;
    final_report;
  end
endmodule : io_controller_load_functions_test

// >>> verif/ioc_load_properties.sv
// Checker: port-level properties of the load functions block
module ioc_load_properties
  import ioc_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Watched ports
  input ioc_pkg::host_wr_t      host,
  input wire logic [DATA_W-1:0] irq_ack,
  input wire logic              ext_in7,
  input wire logic [DATA_W-1:0] port_out_n,
  input wire logic [DATA_W-1:0] xmit_data,
  input wire logic              xmit_load,
  input ioc_pkg::line_cfg_t     line_cfg,
  input wire logic [DATA_W-1:0] irq_reg,
  input wire logic              int_req
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LO = 2 * TICK_COUNT + 1;
  localparam int HI = 3 * TICK_COUNT + 3;
  logic [DATA_W-1:0] mask;
  logic              w_port, w_xmit, w_rate, w_disc, w_t1;
  // Decoded write strobes
  assign w_port = host.wr && host.fn == FN_PORT;
  assign w_xmit = host.wr && host.fn == FN_XMIT;
  assign w_rate = host.wr && host.fn == FN_RATE;
  assign w_disc = host.wr && host.fn == FN_DISCRETE;
  assign w_t1   = host.wr && host.fn == FN_TIMER1;
  // Mask copy, since the real one is hidden inside the block
  always_ff @(posedge clk) begin
    if (!rst_n) mask <= '0;
    else if (host.wr && host.fn == FN_MASK) mask <= host.data;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_port_invert: assert property (
    w_port |=> port_out_n == ~$past(host.data)) else $error("port value");
  chk_port_hold: assert property (
    !w_port |=> $stable(port_out_n)) else $error("port moved");
  chk_xmit_copy: assert property (
    w_xmit |=> xmit_data == $past(host.data) && xmit_load)
    else $error("buffer load");
  chk_stop_bit: assert property (
    w_rate |=> line_cfg.one_stop == $past(host.data[RATE_STOP_BIT]))
    else $error("stop bit");
  chk_int_pending: assert property (
    int_req == |(irq_reg & mask)) else $error("pending output");
  chk_zero_load: assert property (
    w_t1 && host.data == 8'h00 |-> ##2 irq_reg[IRQ_TIMER1])
    else $error("zero load late");
  chk_timer_span: assert property (
    w_t1 && host.data == 8'h03 && !irq_reg[IRQ_TIMER1]
    |-> ##[LO:HI] $rose(irq_reg[IRQ_TIMER1])) else $error("timer span");
  chk_reset_cmd: assert property (
    w_disc && host.data[CMD_RESET_BIT] |=> irq_reg[IRQ_XMIT]
    ##2 (!irq_reg[IRQ_TIMER2]) [*8]) else $error("reset command");
endmodule : ioc_load_properties

bind io_controller_load_functions ioc_load_properties #(
  .TICK_COUNT(TICK_COUNT)
) chk_u (.clk, .rst_n, .host, .irq_ack, .ext_in7, .port_out_n,
  .xmit_data, .xmit_load, .line_cfg, .irq_reg, .int_req);
